// ==== apcl_pkg.sv ====
// apcl_pkg: register map, field codes and sizes for the position compare and latch unit
// assumes: one axis per instance, APB slave with 32-bit data, 125 MHz clock
package apcl_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE0 = 8'h04;
    localparam logic [7:0] OFS_MODE1 = 8'h08;
    localparam logic [7:0] OFS_DATA0 = 8'h0C;
    localparam logic [7:0] OFS_DATA1 = 8'h10;
    localparam logic [7:0] OFS_DATA2 = 8'h14;
    localparam logic [7:0] OFS_DATA3 = 8'h18;
    localparam logic [7:0] OFS_DATA4 = 8'h1C;
    localparam logic [7:0] OFS_AUTO = 8'h20;
    localparam logic [7:0] OFS_EVENT = 8'h24;
    localparam logic [7:0] OFS_CMPSTS = 8'h28;
    localparam logic [7:0] OFS_LATCH = 8'h2C;
    localparam logic [7:0] OFS_TABLE = 8'h30;
    localparam logic [7:0] OFS_VCHG = 8'h34;
    localparam logic [7:0] OFS_FORCE = 8'h38;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CTRL_LATCH_POL = 0;
    localparam int CTRL_SOFT_EN = 1;
    localparam int CTRL_SOFT_ACT = 2;
    localparam int CTRL_ERR_EN = 4;
    localparam int CTRL_TRIG_STYLE = 5;
    localparam int CTRL_RING_SRC = 8;
    localparam int CTRL_LATCH_SEL = 12;
    // ----------------------------------------
    // event status bits
    // ----------------------------------------
    localparam int EV_STEP_LOSS = 10;
    localparam int EV_GENERAL = 11;
    localparam int EV_TRIGGER = 12;
    localparam int EV_SOFT_POS = 0;
    localparam int EV_SOFT_NEG = 1;
    localparam int EV_LATCH = 2;
    localparam int EV_TABLE_ERR = 3;
    // ----------------------------------------
    // codes and sizes
    // ----------------------------------------
    localparam int NUM_CMP = 5;
    localparam int TABLE_MAX = 1024;
    localparam logic [14:0] TOL_MAX = 15'h7FFF;
    localparam logic [7:0] TRIG_PULSE_CYCLES = 8'h08;
    localparam logic [31:0] HW_REVISION = 32'h0000_0001; // arbitrary value
    typedef enum logic [2:0] {M_NONE, M_EQ, M_EQ_UP, M_EQ_DN, M_GT, M_LT, M_RSV} apcl_method_type;
    typedef enum logic [1:0] {A_INT, A_STOP, A_DECEL, A_SPEED} apcl_action_type;
    typedef enum logic [1:0] {S_OFF, S_FIFO, S_FUNC, S_TABLE} apcl_auto_type;
    typedef enum logic [2:0] {R_OFF, R_LATCH, R_ORIGIN, R_CMP4, R_CMP5} apcl_ring_type;
endpackage : apcl_pkg

// ==== apcl_axis.sv ====
// apcl_axis: one axis of the position compare and latch unit, with APB register slave
// assumes: counters come from the neighbouring counter unit, inputs synchronous to pclk
//
// What the document asks of this block and of its host
// [R1] latch input polarity selectable, last two axes
// [R2] latch captures counters; select one to four
// [R3] soft limit action: int, stop, decelerate
// [R4] enabled soft limit acts like physical limit
// [R5] error above tolerance sets event bit 10
// [R6] general comparator match sets event bit 11
// [R7] trigger match on axes 0-1 pulses, bit 12
// [R8] auto loading overrides written trigger value
// [R9] trigger output style depends on revision
// [R10] comparator status word, one bit each
// [R11] five comparators with default roles
// [R12] source select: command, feedback, error, general
// [R13] match method: equal, directional, greater, less
// [R14] reaction: interrupt, stop, decelerate, speed change
// [R15] auto source: off, fifo, function, table
// [R16] function mode adds one point past end
// [R17] compare table limited to 1024 points
// [R18] reload device picks ram or fifo outputs
// [R19] speed change moves remaining distance, ramps
// [R20] forced trigger pulses on axes 0-1 only
// [R21] ring counter reset on selected source
// [R22] host masks interrupts while auto triggering
// [R23] host decodes interrupt type two-bit code
// [R24] compare every cycle, act next cycle
// [R25] event bits sticky until host acknowledges
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module apcl_axis
    import apcl_pkg::*;
#(
    parameter int AXIS_INDEX = 0,
    parameter int CW = 28,
    parameter int TABLE_DEPTH = 16,
    parameter logic NEWER_REVISION = 1'h1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CW-1:0] command_count,
    input wire logic [CW-1:0] feedback_count,
    input wire logic [CW-1:0] error_count,
    input wire logic [CW-1:0] general_count,
    input wire logic count_up,
    input wire logic count_down,
    input wire logic latch_input,
    input wire logic origin_input,
    output logic compare_trigger,
    output logic [1:0] general_outputs_zero_one,
    output logic event_interrupt,
    output logic stop_now,
    output logic decel_stop,
    output logic sync_signal,
    output logic speed_change,
    output logic ring_reset
);
    initial begin
        if (CW < 16 || CW > 32 || TABLE_DEPTH < 3 || TABLE_DEPTH > TABLE_MAX) begin
            $error("apcl_axis: unsupported parameter values");
        end
    end
    localparam bit TRIG_AXIS = (AXIS_INDEX % 4) < 2;
    localparam bit LATCH_AXIS = (AXIS_INDEX % 4) >= 2;
    localparam int TW = $clog2(TABLE_DEPTH);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [NUM_CMP*8-1:0] mode;
        logic [NUM_CMP*32-1:0] data;
        logic [31:0] auto_cfg;
        logic [31:0] vchg;
        logic [15:0] events;
        logic [4:0] cmp_sts;
        logic [31:0] latched;
        logic latch_prev;
        logic origin_prev;
        logic [4:0] match_prev;
        logic [31:0] auto_point;
        logic [31:0] func_idx;
        logic func_extra_done;
        logic [TABLE_DEPTH*32-1:0] table_mem;
        logic [TW:0] table_len;
        logic [TW:0] table_rd;
        logic [7:0] pulse_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic trig_out;
        logic [1:0] gen_out;
        logic irq;
        logic stop_now;
        logic decel_stop;
        logic sync_sig;
        logic speed_chg;
        logic ring_rst;
    } apcl_state_type;
    apcl_state_type state_reg, state_next;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] pick_count(input logic [1:0] src, input logic [CW-1:0] c0,
        input logic [CW-1:0] c1, input logic [CW-1:0] c2, input logic [CW-1:0] c3);
        logic [CW-1:0] v;
        v = c0;
        case (src) // R12
            2'h1: v = c1;
            2'h2: v = c2;
            2'h3: v = c3;
            default: v = c0;
        endcase
        return 32'(signed'(v));
    endfunction : pick_count
    function automatic logic match_of(input logic [2:0] meth, input logic [31:0] cmpv,
        input logic [31:0] cnt, input logic up, input logic dn);
        logic m;
        m = 1'b0;
        case (meth) // R13
            3'h1: m = (cmpv == cnt);
            3'h2: m = (cmpv == cnt) && up;
            3'h3: m = (cmpv == cnt) && dn;
            3'h4: m = $signed(cmpv) > $signed(cnt);
            3'h5: m = $signed(cmpv) < $signed(cnt);
            default: m = 1'b0;
        endcase
        return m;
    endfunction : match_of
    logic [4:0] match_now;
    logic [31:0] trig_value;
    logic [31:0] abs_err;
    always_comb begin
        abs_err = pick_count(2'h2, command_count, feedback_count, error_count, general_count);
        if (abs_err[31]) begin
            abs_err = 32'(-$signed(abs_err));
        end
        // auto loading replaces the written trigger value
        trig_value = (state_reg.auto_cfg[1:0] != 2'h0) ? state_reg.auto_point : state_reg.data[4*32 +: 32]; // R8
        for (int i = 0; i < NUM_CMP; i++) begin // R11 R24
            match_now[i] = match_of(state_reg.mode[i*8 +: 3], (i == 4) ? trig_value : state_reg.data[i*32 +: 32],
                pick_count(state_reg.mode[i*8+3 +: 2], command_count, feedback_count, error_count,
                general_count), count_up, count_down);
        end
        // step-loss uses magnitude against the tolerance
        match_now[2] = state_reg.ctrl[CTRL_ERR_EN] && (abs_err > {17'h0, state_reg.data[2*32 +: 15]}); // R5
        if (!TRIG_AXIS) begin
            match_now[4] = 1'b0;
        end
    end
    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic access;
    logic latch_level;
    logic [4:0] rise;
    logic [15:0] ev_set;
    logic [31:0] rd;
    logic err;
    always_comb begin
        state_next = state_reg;
        access = psel && penable;
        rd = 32'h0;
        err = 1'b0;
        ev_set = 16'h0;
        state_next.match_prev = match_now;
        rise = match_now & ~state_reg.match_prev;
        state_next.cmp_sts = match_now; // R10
        latch_level = LATCH_AXIS ? (latch_input ~^ state_reg.ctrl[CTRL_LATCH_POL]) : latch_input; // R1
        state_next.latch_prev = latch_level;
        state_next.origin_prev = origin_input;
        state_next.stop_now = 1'b0;
        state_next.decel_stop = 1'b0;
        state_next.sync_sig = 1'b0;
        state_next.speed_chg = 1'b0;
        state_next.ring_rst = 1'b0;
        if (latch_level && !state_reg.latch_prev) begin // R2
            state_next.latched = pick_count(2'(state_reg.ctrl[CTRL_LATCH_SEL +: 3] - 3'h1), command_count,
                feedback_count, error_count, general_count);
            ev_set[EV_LATCH] = 1'b1;
        end
        if (state_reg.ctrl[CTRL_SOFT_EN]) begin // R4
            for (int i = 0; i < 2; i++) begin
                if (rise[i]) begin
                    ev_set[EV_SOFT_POS + i] = 1'b1;
                    case (state_reg.ctrl[CTRL_SOFT_ACT +: 2]) // R3
                        2'h1: state_next.stop_now = 1'b1;
                        2'h2: state_next.decel_stop = 1'b1;
                        default: state_next.sync_sig = state_next.sync_sig;
                    endcase
                end
            end
        end
        if (rise[2]) begin
            ev_set[EV_STEP_LOSS] = 1'b1; // R5
        end
        if (rise[3]) begin
            ev_set[EV_GENERAL] = 1'b1; // R6
            case (state_reg.mode[3*8+5 +: 2]) // R14
                2'h0: state_next.sync_sig = 1'b1;
                2'h1: state_next.stop_now = 1'b1;
                2'h2: state_next.decel_stop = 1'b1;
                default: state_next.speed_chg = 1'b1; // R19
            endcase
        end
        // counted down first, so a new trigger restarts a running pulse
        if (state_reg.pulse_cnt != 8'h0) begin
            state_next.pulse_cnt = state_reg.pulse_cnt - 8'h1;
        end
        if (rise[4] || (state_reg.ctrl[15] && TRIG_AXIS)) begin // R7 R20
            ev_set[EV_TRIGGER] = rise[4];
            state_next.pulse_cnt = TRIG_PULSE_CYCLES;
            state_next.ctrl[15] = 1'b0;
            // next compare point from the auto source
            case (state_reg.auto_cfg[1:0]) // R15
                2'h2: begin // R16
                    // table words: start, end, interval; the point past the end is still loaded
                    if ($signed(state_reg.auto_point) <= $signed(state_reg.table_mem[63:32])) begin
                        state_next.auto_point = state_reg.auto_point + state_reg.table_mem[95:64];
                    end
                end
                2'h1, 2'h3: begin
                    if (state_reg.table_rd + 1'b1 < state_reg.table_len) begin
                        state_next.table_rd = state_reg.table_rd + 1'b1;
                        state_next.auto_point = state_reg.table_mem[(TW+1)'(state_reg.table_rd + 1'b1)*32 +: 32];
                    end
                end
                default: state_next.auto_point = state_reg.auto_point;
            endcase
        end
        case (state_reg.ctrl[CTRL_RING_SRC +: 3]) // R21
            3'h1: state_next.ring_rst = latch_level && !state_reg.latch_prev;
            3'h2: state_next.ring_rst = origin_input && !state_reg.origin_prev;
            3'h3: state_next.ring_rst = rise[3];
            3'h4: state_next.ring_rst = rise[4];
            default: state_next.ring_rst = 1'b0;
        endcase
        // trigger style: older one-shot or level, newer polarity
        if (NEWER_REVISION) begin // R9
            state_next.trig_out = (state_next.pulse_cnt != 8'h0) ^ ~state_reg.ctrl[CTRL_TRIG_STYLE];
        end else begin
            state_next.trig_out = (state_next.pulse_cnt != 8'h0) || (state_reg.ctrl[CTRL_TRIG_STYLE] && match_now[4]);
        end
        state_next.gen_out = {2{state_reg.auto_cfg[2] == 1'b0 && state_next.pulse_cnt != 8'h0}}; // R18
        // ----------------------------------------
        // apb
        // ----------------------------------------
        state_next.pready = access && !state_reg.pready;
        state_next.pslverr = 1'b0;
        if (access && !state_reg.pready) begin
            case (paddr)
                OFS_CTRL: rd = {16'h0, state_reg.ctrl};
                OFS_MODE0: rd = state_reg.mode[31:0];
                OFS_MODE1: rd = {24'h0, state_reg.mode[39:32]};
                OFS_DATA0, OFS_DATA1, OFS_DATA2, OFS_DATA3, OFS_DATA4:
                    rd = state_reg.data[(paddr - OFS_DATA0) * 8 +: 32];
                OFS_AUTO: rd = state_reg.auto_cfg;
                OFS_EVENT: rd = {16'h0, state_reg.events};
                OFS_CMPSTS: rd = {27'h0, state_reg.cmp_sts};
                OFS_LATCH: rd = state_reg.latched;
                OFS_TABLE: rd = 32'(state_reg.table_len);
                OFS_VCHG: rd = state_reg.vchg;
                OFS_FORCE: rd = HW_REVISION;
                default: err = 1'b1;
            endcase
            if (pwrite) begin
                case (paddr)
                    OFS_CTRL: state_next.ctrl = pwdata[15:0];
                    OFS_MODE0: state_next.mode[31:0] = pwdata;
                    OFS_MODE1: state_next.mode[39:32] = pwdata[7:0];
                    OFS_DATA0, OFS_DATA1, OFS_DATA2, OFS_DATA3, OFS_DATA4:
                        state_next.data[(paddr - OFS_DATA0) * 8 +: 32] = pwdata;
                    OFS_AUTO: begin
                        state_next.auto_cfg = pwdata;
                        state_next.table_rd = '0;
                        state_next.auto_point = state_reg.table_mem[31:0];
                    end
                    OFS_EVENT: state_next.events = state_reg.events & ~pwdata[15:0]; // R25
                    OFS_TABLE: begin
                        if (state_reg.table_len < (TW+1)'(TABLE_DEPTH)) begin // R17
                            state_next.table_mem[state_reg.table_len*32 +: 32] = pwdata;
                            state_next.table_len = state_reg.table_len + 1'b1;
                        end else begin
                            ev_set[EV_TABLE_ERR] = 1'b1;
                            err = 1'b1;
                        end
                    end
                    OFS_VCHG: state_next.vchg = pwdata;
                    OFS_FORCE: begin
                        state_next.ctrl[15] = 1'b1;
                        state_next.table_len = '0;
                    end
                    default: err = 1'b1;
                endcase
            end
            state_next.pslverr = err;
        end
        state_next.prdata = rd;
        state_next.events = state_next.events | ev_set; // R25
        state_next.irq = |state_next.events;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // trigger pin rests at its idle level, so leaving reset makes no false edge
            state_reg <= '0;
            state_reg.trig_out <= NEWER_REVISION;
        end else begin
            state_reg <= state_next;
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign compare_trigger = state_reg.trig_out;
    assign general_outputs_zero_one = state_reg.gen_out;
    assign event_interrupt = state_reg.irq;
    assign stop_now = state_reg.stop_now;
    assign decel_stop = state_reg.decel_stop;
    assign sync_signal = state_reg.sync_sig;
    assign speed_change = state_reg.speed_chg;
    assign ring_reset = state_reg.ring_rst;
endmodule : apcl_axis
`default_nettype wire

// ==== apcl_axis_sva.sv ====
// apcl_axis_sva: bus timing and pulse checks beside apcl_axis
// assumes: bound into apcl_axis, one pclk domain, presetn active low
`timescale 1ns/100ps
`default_nettype none
module apcl_axis_sva
    import apcl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic event_interrupt,
    input wire logic stop_now,
    input wire logic sync_signal,
    input wire logic ring_reset
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    access_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    answer_qual_a: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    answer_once_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    error_qual_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    unmapped_err_a: assert property (psel && penable && !pready && paddr > 8'h38 |=> pslverr)
        else $error("unmapped access not refused");
    // ----------------------------------------
    // events and reactions
    // ----------------------------------------
    event_hold_a: assert property (event_interrupt && !(psel && pwrite && paddr == OFS_EVENT) |=> event_interrupt)
        else $error("event dropped without clear");
    stop_pulse_a: assert property (stop_now |=> !stop_now)
        else $error("stop longer than one cycle");
    sync_event_a: assert property (sync_signal |-> ##[0:2] event_interrupt)
        else $error("sync without interrupt");
    ring_pulse_a: assert property (ring_reset |=> !ring_reset)
        else $error("ring reset longer than one cycle");
endmodule : apcl_axis_sva
bind apcl_axis apcl_axis_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .event_interrupt(event_interrupt),
    .stop_now(stop_now), .sync_signal(sync_signal), .ring_reset(ring_reset));
`default_nettype wire

// ==== apcl_drive.sv ====
// apcl_drive: drive and encoder model feeding the axis counters
// assumes: one step per pclk, encoder echoes command one cycle late
`timescale 1ns/100ps
`default_nettype none
module apcl_drive #(
    parameter int CW = 28
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CW-1:0] target,
    input wire logic slip,
    input wire logic halt,
    output logic [CW-1:0] command_count,
    output logic [CW-1:0] feedback_count,
    output logic [CW-1:0] error_count,
    output logic [CW-1:0] general_count,
    output logic count_up,
    output logic count_down,
    output logic moving
);
    logic stopped_reg;
    logic [CW-1:0] aim_reg;
    assign moving = command_count != target && !stopped_reg;
    assign count_up = moving && target > command_count;
    assign count_down = moving && target < command_count;
    assign error_count = command_count - feedback_count;
    assign general_count = feedback_count;
    // slip freezes the encoder, so steps are lost on purpose
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_count <= '0;
            feedback_count <= '0;
            stopped_reg <= 1'h0;
            aim_reg <= '0;
        end else begin
            aim_reg <= target;
            stopped_reg <= (stopped_reg && aim_reg == target) || halt;
            if (count_up) command_count <= command_count + CW'(1);
            if (count_down) command_count <= command_count - CW'(1);
            if (!slip) feedback_count <= command_count;
        end
    end
endmodule : apcl_drive
`default_nettype wire

// ==== tb_apcl_axis.sv ====
// tb_apcl_axis: self-checking bench for apcl_axis over APB
// assumes: axis 0 instance, apcl_drive supplies the counters
`timescale 1ns/100ps
`default_nettype none
module tb_apcl_axis import apcl_pkg::*;;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, trig, trig_q, clr = 1'h0, slip = 1'h0, origin_input = 1'h0;
    logic count_up, count_down, moving, evi, stop_now, decel_stop, sync_signal, speed_change, ring_reset;
    logic [27:0] target = 28'h0, cmd, fb, ec, gc;
    logic [5:0] seen;
    logic [1:0] gen_out;
    logic latch_pin = 1'h0;
    int miscompares = 0, total_checks = 0;
    // method, target alternates 40/60 through 50, expected firing
    localparam logic [23:0] METHODS = {3'h1, 3'h4, 3'h5, 3'h3, 3'h3, 3'h2, 3'h2, 3'h0};
    localparam logic [7:0] FIRES = 8'hF2;
    initial forever #4 pclk = ~pclk;
    apcl_drive u_drive (.pclk(pclk), .presetn(presetn), .target(target), .slip(slip),
        .halt(stop_now || decel_stop), .command_count(cmd), .feedback_count(fb), .error_count(ec),
        .general_count(gc), .count_up(count_up), .count_down(count_down), .moving(moving));
    apcl_axis #(.AXIS_INDEX(0)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .command_count(cmd), .feedback_count(fb), .error_count(ec),
        .general_count(gc), .count_up(count_up), .count_down(count_down), .latch_input(latch_pin),
        .origin_input(origin_input), .compare_trigger(trig), .general_outputs_zero_one(gen_out),
        .event_interrupt(evi), .stop_now(stop_now), .decel_stop(decel_stop), .sync_signal(sync_signal),
        .speed_change(speed_change), .ring_reset(ring_reset));
    // pulses are one cycle wide, so they are caught here rather than polled
    always @(posedge pclk) begin
        trig_q <= trig;
        seen <= clr ? 6'h0 : seen | {trig ^ trig_q, ring_reset, speed_change, decel_stop, stop_now, sync_signal};
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 16) begin
            miscompares++;
            conclude();
        end
    endtask : apb
    task automatic go(input logic [27:0] t);
        int n;
        n = 0;
        target <= t;
        do begin
            @(posedge pclk);
            n++;
        end while ((moving === 1'h1 || n < 4) && n < 400);
        if (n >= 400) begin
            miscompares++;
            conclude();
        end
    endtask : go
    task automatic clear;
        clr <= 1'h1;
        @(posedge pclk);
        clr <= 1'h0;
    endtask : clear
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        clear();
        apb(1'h0, OFS_EVENT, 32'h0);
        chk(q, 32'h0);
        apb(1'h0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // ----------------------------------------
        // step loss at the tolerance boundary
        // ----------------------------------------
        apb(1'h1, OFS_DATA2, 32'h5);
        apb(1'h1, OFS_CTRL, 32'h10);
        slip <= 1'h1;
        go(28'h5);
        apb(1'h0, OFS_EVENT, 32'h0);
        chk({31'h0, q[EV_STEP_LOSS]}, 32'h0);
        go(28'h6);
        apb(1'h0, OFS_EVENT, 32'h0);
        chk({31'h0, q[EV_STEP_LOSS]}, 32'h1);
        // host type code: error in bit 0, event in bit 1; this block has no error source
        chk({30'h0, evi, 1'h0}, 32'h2);
        slip <= 1'h0;
        apb(1'h1, OFS_CTRL, 32'h0);
        go(28'h64);
        // ----------------------------------------
        // general comparator, every method
        // ----------------------------------------
        apb(1'h1, OFS_DATA3, 32'h32);
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, OFS_MODE0, {5'h0, METHODS[i*3+:3], 24'h0});
            apb(1'h1, OFS_EVENT, 32'hFFFF_FFFF);
            clear();
            go(i[0] ? 28'h3C : 28'h28);
            apb(1'h0, OFS_EVENT, 32'h0);
            chk({31'h0, q[EV_GENERAL]}, {31'h0, FIRES[i]});
            chk({31'h0, seen[0]}, {31'h0, FIRES[i]});
        end
        // every reaction, point 10 ahead of the drive
        for (int a = 0; a < 4; a++) begin
            apb(1'h1, OFS_DATA3, {4'h0, cmd + 28'hA});
            apb(1'h1, OFS_MODE0, {1'h0, a[1:0], 5'h01, 24'h0});
            clear();
            go(cmd + 28'h1E);
            chk({31'h0, seen[a]}, 32'h1);
        end
        // ----------------------------------------
        // trigger comparator, auto source masks manual point
        // ----------------------------------------
        // other interrupt sources stay off while auto loading runs
        apb(1'h1, OFS_MODE0, 32'h0);
        apb(1'h1, OFS_MODE1, 32'h9);
        for (int j = 0; j < 2; j++) begin
            apb(1'h1, OFS_AUTO, j == 0 ? 32'h5 : 32'h0);
            apb(1'h1, OFS_DATA4, {4'h0, cmd + 28'hA});
            apb(1'h1, OFS_EVENT, 32'hFFFF_FFFF);
            clear();
            go(cmd + 28'h14);
            apb(1'h0, OFS_EVENT, 32'h0);
            chk({31'h0, q[EV_TRIGGER]}, j);
            chk({31'h0, seen[5]}, j);
        end
        clear();
        apb(1'h1, OFS_FORCE, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, seen[5]}, 32'h1);
        chk({30'h0, gen_out}, 32'h3);
        // ring reset on origin, latch picks the feedback counter
        apb(1'h1, OFS_CTRL, 32'h2200);
        clear();
        origin_input <= 1'h1;
        latch_pin <= 1'h1;
        repeat (3) @(posedge pclk);
        origin_input <= 1'h0;
        latch_pin <= 1'h0;
        chk({31'h0, seen[4]}, 32'h1);
        apb(1'h0, OFS_LATCH, 32'h0);
        chk(q, {4'h0, fb});
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OFS_EVENT, 32'h0);
        chk(q, 32'h0);
        conclude();
    end
endmodule : tb_apcl_axis
`default_nettype wire
